// *** inc/port_pin_pkg.sv ***
// Constants and types shared by the port pin mode control block
//
// Functional notes
// - Direction bit 0 output, 1 input
// - Output with control 00 leaves pin floating
// - Output control 01 drives high only
// - Output control 10 drives low only
// - Output control 11 drives both levels
// - Input control 00 or 11 no pulls
// - Input control 01 enables pull-down
// - Input control 10 enables pull-up
// - Reset gives floating output on all pins
// - Output pins follow data register bits
// - Input pins read back their sampled level
// - Bit n controls pin n only
// - Segment select hands pins to segment driver
// - Written data reads back in output mode
// - Control bytes accessible singly or as word
`default_nettype none

package port_pin_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned PINS   = 8;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PIN_LEVEL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] PIN_DIR_OFF   = 8'h04;
  localparam logic [ADDR_W-1:0] DRIVE_SEL_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] SEG_SEL_OFF   = 8'h0c;
  localparam logic [ADDR_W-1:0] RAW_LEVEL_OFF = 8'h10;

  // Field positions inside the drive select word
  localparam int unsigned SEL_LOW_LSB  = 0;
  localparam int unsigned SEL_HIGH_LSB = 8;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] LEVEL_RST   = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'h00;
  localparam logic [7:0] SEL_LOW_RST = 8'h00;
  localparam logic [7:0] SEL_HI_RST  = 8'h00;
  localparam logic [7:0] SEG_RST     = 8'h00;
  localparam logic [7:0] SYNC_RST    = 8'h00;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // Direction and control codes
  // ---------------------------------------------------------------
  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT  = 1'b1;

  typedef enum logic [1:0] {
    CTL_FLOAT  = 2'h0,
    CTL_PSIDE  = 2'h1,
    CTL_NSIDE  = 2'h2,
    CTL_BOTH   = 2'h3
  } ctl_code_t;

  // Pad control bundle for one pin
  typedef struct packed {
    logic drive_high;
    logic drive_low;
    logic pull_up;
    logic pull_down;
  } pad_ctl_t;

endpackage

`default_nettype wire

// *** verilog/level_sync.sv ***
// Two-stage synchroniser for a vector of pin levels
`default_nettype none

module level_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out
);
  import port_pin_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  // ---------------------------------------------------------------
  // Stage chain
  // ---------------------------------------------------------------
  // first stage feeds only second
  always_comb begin
    state_d        = state_q;
    state_d.meta   = level_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign level_out = state_q.stable;

endmodule

`default_nettype wire

// *** verilog/port_pin_mode_control.sv ***
// Per-pin mode control of an eight-pin port with an APB register slave
`default_nettype none

module port_pin_mode_control #(
  parameter int unsigned PIN_COUNT = port_pin_pkg::PINS
) (
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [port_pin_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [port_pin_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [port_pin_pkg::STRB_W-1:0]   pstrb,
  output logic      [port_pin_pkg::DATA_W-1:0]   prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Pad levels
  input  wire logic [PIN_COUNT-1:0]              pad_in,
  output logic      [PIN_COUNT-1:0]              pad_out,
  output logic      [PIN_COUNT-1:0]              pad_oe_n,
  // Pad drive and pull controls
  output logic      [PIN_COUNT-1:0]              drive_high_en,
  output logic      [PIN_COUNT-1:0]              drive_low_en,
  output logic      [PIN_COUNT-1:0]              pull_up_en,
  output logic      [PIN_COUNT-1:0]              pull_down_en,
  // Segment driver hand-over
  output logic      [PIN_COUNT-1:0]              segment_function_select
);
  import port_pin_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_level_register;
    logic [PIN_COUNT-1:0] pin_direction_register;
    logic [PIN_COUNT-1:0] drive_select_low_bits;
    logic [PIN_COUNT-1:0] drive_select_high_bits;
    logic [PIN_COUNT-1:0] segment_sel;
    logic [DATA_W-1:0]    rdata;
    logic                 err;
  } port_state_t;

  port_state_t state_q;
  port_state_t state_d;

  logic [PIN_COUNT-1:0] level_synced;
  logic [PIN_COUNT-1:0] level_view;
  logic                 setup_phase;
  logic                 write_fire;
  logic                 addr_known;
  pad_ctl_t [PIN_COUNT-1:0] pad_ctl;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Address compare used by every register
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    hit = (addr == off);
  endfunction

  // Merge one byte lane of write data into a register
  function automatic logic [7:0] lane_merge(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic       lane_en
  );
    lane_merge = lane_en ? new_val : old_val;
  endfunction

  // Widen an eight-bit value onto the bus, upper bits zero
  function automatic logic [DATA_W-1:0] widen8(
    input logic [7:0] val
  );
    widen8 = {{(DATA_W-8){1'b0}}, val};
  endfunction

  // Decode one pin into its pad controls
  function automatic pad_ctl_t pin_decode(
    input logic dir,
    input logic sel_high,
    input logic sel_low,
    input logic level,
    input logic seg
  );
    ctl_code_t code;
    pad_ctl_t  res;
    code = ctl_code_t'({sel_high, sel_low});
    res  = '0;
    if (seg) begin
      // Segment driver owns the pad; port stays silent
      res = '0;
    end else if (dir == DIR_OUTPUT) begin
      case (code)
        CTL_FLOAT: begin
          res = '0;
        end
        CTL_PSIDE: begin
          res.drive_high = level;
        end
        CTL_NSIDE: begin
          res.drive_low = ~level;
        end
        CTL_BOTH: begin
          res.drive_high = level;
          res.drive_low  = ~level;
        end
        default: begin
          res = '0;
        end
      endcase
    end else begin
      case (code)
        CTL_PSIDE: begin
          res.pull_down = 1'b1;
        end
        CTL_NSIDE: begin
          res.pull_up = 1'b1;
        end
        CTL_FLOAT, CTL_BOTH: begin
          res = '0;
        end
        default: begin
          res = '0;
        end
      endcase
    end
    pin_decode = res;
  endfunction

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  // two stages before readback
  level_sync #(
    .WIDTH (PIN_COUNT)
  ) u_level_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .level_in  (pad_in),
    .level_out (level_synced)
  );

  // ---------------------------------------------------------------
  // Readback of the level register
  // ---------------------------------------------------------------
  // input pins show sampled level
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (state_q.pin_direction_register[i] == DIR_INPUT) begin
        level_view[i] = level_synced[i];
      end else begin
        level_view[i] = state_q.pin_level_register[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus phase decode
  // ---------------------------------------------------------------
  // Zero wait states; read data is captured in the setup cycle
  assign setup_phase = psel & ~penable;
  assign write_fire  = psel & penable & pwrite;
  assign addr_known  = hit(paddr, PIN_LEVEL_OFF) |
                       hit(paddr, PIN_DIR_OFF)   |
                       hit(paddr, DRIVE_SEL_OFF) |
                       hit(paddr, SEG_SEL_OFF)   |
                       hit(paddr, RAW_LEVEL_OFF);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // Read data and error flag prepared ahead of the access cycle
    if (setup_phase) begin
      state_d.err   = ~addr_known;
      state_d.rdata = '0;
      if (!pwrite) begin
        case (1'b1)
          hit(paddr, PIN_LEVEL_OFF): begin
            state_d.rdata = widen8(level_view);
          end
          hit(paddr, PIN_DIR_OFF): begin
            state_d.rdata = widen8(state_q.pin_direction_register);
          end
          hit(paddr, DRIVE_SEL_OFF): begin
            state_d.rdata[SEL_LOW_LSB +: 8] =
              state_q.drive_select_low_bits;
            state_d.rdata[SEL_HIGH_LSB +: 8] =
              state_q.drive_select_high_bits;
          end
          hit(paddr, SEG_SEL_OFF): begin
            state_d.rdata = widen8(state_q.segment_sel);
          end
          hit(paddr, RAW_LEVEL_OFF): begin
            state_d.rdata = widen8(level_synced);
          end
          default: begin
            state_d.rdata = '0;
          end
        endcase
      end
    end

    // Writes land only on the access edge; errored ones are dropped
    if (write_fire && addr_known) begin
      case (1'b1)
        hit(paddr, PIN_LEVEL_OFF): begin
          state_d.pin_level_register = lane_merge(
            state_q.pin_level_register, pwdata[7:0], pstrb[0]);
        end
        hit(paddr, PIN_DIR_OFF): begin
          state_d.pin_direction_register = lane_merge(
            state_q.pin_direction_register, pwdata[7:0], pstrb[0]);
        end
        hit(paddr, DRIVE_SEL_OFF): begin
          state_d.drive_select_low_bits = lane_merge(
            state_q.drive_select_low_bits,
            pwdata[SEL_LOW_LSB +: 8], pstrb[0]);
          state_d.drive_select_high_bits = lane_merge(
            state_q.drive_select_high_bits,
            pwdata[SEL_HIGH_LSB +: 8], pstrb[1]);
        end
        hit(paddr, SEG_SEL_OFF): begin
          state_d.segment_sel = lane_merge(
            state_q.segment_sel, pwdata[7:0], pstrb[0]);
        end
        default: begin
          state_d.err = state_q.err;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q.pin_level_register     <= LEVEL_RST;
      state_q.pin_direction_register <= DIR_RST;
      state_q.drive_select_low_bits  <= SEL_LOW_RST;
      state_q.drive_select_high_bits <= SEL_HI_RST;
      state_q.segment_sel            <= SEG_RST;
      state_q.rdata                  <= '0;
      state_q.err                    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign prdata  = state_q.rdata;
  assign pslverr = psel & penable & state_q.err;

  // ---------------------------------------------------------------
  // Per-pin pad decode
  // ---------------------------------------------------------------
  // pin n uses bit n only
  generate
    for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
      assign pad_ctl[n] = pin_decode(
        state_q.pin_direction_register[n],
        state_q.drive_select_high_bits[n],
        state_q.drive_select_low_bits[n],
        state_q.pin_level_register[n],
        state_q.segment_sel[n]);
      assign drive_high_en[n] = pad_ctl[n].drive_high;
      assign drive_low_en[n]  = pad_ctl[n].drive_low;
      assign pull_up_en[n]    = pad_ctl[n].pull_up;
      assign pull_down_en[n]  = pad_ctl[n].pull_down;
      // Enable is low only while one side actively drives
      assign pad_oe_n[n] = ~(pad_ctl[n].drive_high |
                             pad_ctl[n].drive_low);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pad level and hand-over
  // ---------------------------------------------------------------
  // output level from data bits
  assign pad_out = state_q.pin_level_register;

  assign segment_function_select = state_q.segment_sel;

endmodule

`default_nettype wire

// *** tb/port_pin_props.sv ***
// Port-level assertions for the port pin mode control block
`default_nettype none

module port_pin_props
  import port_pin_pkg::*;
#(
  parameter int unsigned PIN_COUNT = port_pin_pkg::PINS
) (
  // Clock and reset
  input wire logic                              core_clk,
  input wire logic                              reset,
  // APB slave
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [port_pin_pkg::ADDR_W-1:0]   paddr,
  input wire logic [port_pin_pkg::DATA_W-1:0]   pwdata,
  input wire logic [port_pin_pkg::STRB_W-1:0]   pstrb,
  input wire logic [port_pin_pkg::DATA_W-1:0]   prdata,
  // Pads
  input wire logic [PIN_COUNT-1:0]              pad_in,
  input wire logic [PIN_COUNT-1:0]              pad_out,
  input wire logic [PIN_COUNT-1:0]              pad_oe_n,
  input wire logic [PIN_COUNT-1:0]              drive_high_en,
  input wire logic [PIN_COUNT-1:0]              drive_low_en,
  input wire logic [PIN_COUNT-1:0]              pull_up_en,
  input wire logic [PIN_COUNT-1:0]              pull_down_en,
  input wire logic [PIN_COUNT-1:0]              segment_function_select
);
  logic [2:0] up_q;
  logic       acc;

  assign acc = psel && penable;

  // Synchroniser shows reset zeros for a few edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h4) begin
      up_q <= up_q + 3'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_lvl_wr;
    acc && pwrite && pstrb[0] && paddr == PIN_LEVEL_OFF;
  endsequence
  sequence s_pins_still;
    $stable(pad_in)[*4];
  endsequence
  sequence s_raw_rd;
    acc && !pwrite && up_q == 3'h4 && paddr == RAW_LEVEL_OFF;
  endsequence

  property p_oe;
    pad_oe_n == ~(drive_high_en | drive_low_en);
  endproperty
  a_oe: assert property (p_oe) else $error("oe vs drives");
  property p_hi;
    (drive_high_en & ~pad_out) == '0;
  endproperty
  a_hi: assert property (p_hi) else $error("high drive of 0");
  property p_lo;
    (drive_low_en & pad_out) == '0;
  endproperty
  a_lo: assert property (p_lo) else $error("low drive of 1");
  property p_mode;
    ((pull_up_en | pull_down_en) & ~pad_oe_n) == '0;
  endproperty
  a_mode: assert property (p_mode) else $error("pull and drive");
  property p_pulls;
    (pull_up_en & pull_down_en) == '0;
  endproperty
  a_pulls: assert property (p_pulls) else $error("both pulls");
  property p_seg;
    (segment_function_select & (~pad_oe_n | pull_up_en | pull_down_en))
      == '0;
  endproperty
  a_seg: assert property (p_seg) else $error("segment pin used");
  property p_lvl_wr;
    s_lvl_wr |=> pad_out == $past(pwdata[PIN_COUNT-1:0]);
  endproperty
  a_lvl_wr: assert property (p_lvl_wr) else $error("data lost");
  property p_raw;
    s_pins_still ##0 s_raw_rd |-> prdata[PIN_COUNT-1:0] == pad_in;
  endproperty
  a_raw: assert property (p_raw) else $error("pin level read");
  property p_hold;
    !(acc && pwrite) |=> $stable({pad_out, pad_oe_n, pull_up_en,
      pull_down_en, segment_function_select});
  endproperty
  a_hold: assert property (p_hold) else $error("pads moved");
endmodule

bind port_pin_mode_control port_pin_props #(.PIN_COUNT(PIN_COUNT))
  u_port_pin_props (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pad_in(pad_in), .pad_out(pad_out),
  .pad_oe_n(pad_oe_n), .drive_high_en(drive_high_en),
  .drive_low_en(drive_low_en), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en),
  .segment_function_select(segment_function_select));

`default_nettype wire

// *** tb/tb_port_pin_mode_control.sv ***
// Self-checking bench for the port pin mode control block
`default_nettype none

module tb_port_pin_mode_control
  import port_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              core_clk, reset, psel, penable, pwrite;
  logic              pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [STRB_W-1:0] pstrb;
  logic [PINS-1:0]   pad_in, pad_out, oe_n, dh, dl, pu, pd, seg;
  int                fails = 0;
  int                checks_done = 0;

  port_pin_mode_control u_port_pin_mode_control (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(oe_n),
    .drive_high_en(dh), .drive_low_en(dl), .pull_up_en(pu),
    .pull_down_en(pd), .segment_function_select(seg));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Waits on pready; never assumes the zero-wait answer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, e, m);
    chk(err, 1'b0, m);
  endtask

  function automatic logic [39:0] pads(input logic [7:0] dr, hi, lo,
                                       dt, sg);
    logic [7:0] o;
    logic [7:0] h;
    logic [7:0] l;
    o = ~dr & ~sg;
    h = o & lo & dt;
    l = o & hi & ~dt;
    return {~(h | l), h, l, dr & ~sg & hi & ~lo, dr & ~sg & lo & ~hi};
  endfunction

  task automatic chk_pads(input logic [39:0] e, input string m);
    chk({oe_n, dh, dl, pu, pd}, e, m);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    rdc(PIN_LEVEL_OFF, 32'h0, "level rst");
    rdc(PIN_DIR_OFF, 32'h0, "dir rst");
    rdc(DRIVE_SEL_OFF, 32'h0, "sel rst");
    rdc(SEG_SEL_OFF, 32'h0, "seg rst");
    chk_pads({8'hff, 32'h0}, "pads rst");
    chk(pad_out, 8'h00, "out rst");
    $display("test reset done");
  endtask

  // Pins 7..0 walk all eight direction and code pairs
  task automatic t_modes();
    logic [7:0] dt;
    wr(PIN_DIR_OFF, 32'hf0);
    wr(DRIVE_SEL_OFF, 32'hccaa);
    for (int i = 0; i < 2; i++) begin
      dt = i ? 8'haa : 8'h55;
      wr(PIN_LEVEL_OFF, {24'h0, dt});
      chk(pad_out, dt, "pad out");
      chk_pads(pads(8'hf0, 8'hcc, 8'haa, dt, 8'h0), "modes");
    end
    $display("test modes done");
  endtask

  task automatic t_seg();
    wr(SEG_SEL_OFF, 32'h3c);
    chk_pads(pads(8'hf0, 8'hcc, 8'haa, 8'haa, 8'h3c), "seg");
    chk(seg, 8'h3c, "seg pins");
    rdc(SEG_SEL_OFF, 32'h3c, "seg rd");
    wr(SEG_SEL_OFF, 32'h0);
    $display("test segment done");
  endtask

  task automatic t_bytes();
    apb(1'b1, DRIVE_SEL_OFF, 32'habcd_33cc, 4'h3);
    rdc(DRIVE_SEL_OFF, 32'h33cc, "sel word");
    apb(1'b1, DRIVE_SEL_OFF, 32'h0000_ff11, 4'h2);
    rdc(DRIVE_SEL_OFF, 32'hffcc, "sel high");
    apb(1'b1, DRIVE_SEL_OFF, 32'h0000_ff11, 4'h1);
    rdc(DRIVE_SEL_OFF, 32'hff11, "sel low");
    chk_pads(pads(8'hf0, 8'hff, 8'h11, 8'haa, 8'h0), "bytes");
    $display("test bytes done");
  endtask

  // First read is launched after three edges have passed
  task automatic t_level();
    wr(PIN_DIR_OFF, 32'h0f);
    wr(PIN_LEVEL_OFF, 32'h5a);
    pad_in <= 8'h96;
    repeat (3) @(posedge core_clk);
    rdc(PIN_LEVEL_OFF, 32'h56, "mixed");
    rdc(RAW_LEVEL_OFF, 32'h96, "raw");
    chk(pad_out, 8'h5a, "held out");
    pad_in <= 8'h69;
    @(posedge core_clk);
    rdc(RAW_LEVEL_OFF, 32'h96, "sync old");
    rdc(RAW_LEVEL_OFF, 32'h69, "sync new");
    $display("test level done");
  endtask

  task automatic t_bad();
    apb(1'b1, 8'h14, 32'hff, 4'hf);
    chk(err, 1'b1, "bad wr");
    chk(pad_out, 8'h5a, "bad wr kept");
    apb(1'b1, PIN_LEVEL_OFF, 32'hff, 4'he);
    chk(pad_out, 8'h5a, "lane off kept");
    apb(1'b0, 8'h14, 32'h0, 4'hf);
    chk({err, rd}, {1'b1, 32'h0}, "bad rd");
    wr(RAW_LEVEL_OFF, 32'h0);
    chk(err, 1'b0, "ro wr");
    rdc(RAW_LEVEL_OFF, 32'h69, "ro kept");
    $display("test bad access done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = '0;
    pad_in  = 8'h00;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_modes();
    t_seg();
    t_bytes();
    t_level();
    t_bad();
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    final_report();
  end

  // About 110 cycles expected; eighteen times that is a hang
  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule

`default_nettype wire
